// [design/tcm_pkg.sv]
package tcm_pkg;

    // Number of timer units served by one control block.
    localparam int NUM_UNITS = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [31:0] IDX_CTL0 [NUM_UNITS] = '{32'hfffff690, 32'h0ffff6a0};
    localparam logic [31:0] IDX_CTL1 [NUM_UNITS] = '{32'hfffff691, 32'hfffff6a1};
    localparam logic [31:0] IDX_CTL2 [NUM_UNITS] = '{32'hfffff692, 32'hfffff6a2};
    localparam logic [31:0] IDX_CNT  [NUM_UNITS] = '{32'hfffff69e, 32'hfffff6ae};
    localparam logic [31:0] IDX_TCW  [NUM_UNITS] = '{32'hfffff990, 32'hfffff9a0};

    // Field positions of control register 0.
    localparam int CTL0_CE  = 7;
    localparam int CTL0_CKS = 0;
    // Field positions of control register 1.
    localparam int CTL1_EST = 6;
    localparam int CTL1_EEE = 5;
    localparam int CTL1_MD  = 0;
    // Field positions of control register 2.
    localparam int CTL2_ECC  = 7;
    localparam int CTL2_LDE  = 4;
    localparam int CTL2_ECM1 = 3;
    localparam int CTL2_ECM0 = 2;
    localparam int CTL2_UDS  = 0;

    // Writable bits; the rest read as zero.
    localparam logic [7:0] CTL0_MASK = 8'h87;
    localparam logic [7:0] CTL1_MASK = 8'h2f;
    localparam logic [7:0] CTL2_MASK = 8'h9f;

    // Reset and special counter values.
    localparam logic [7:0]  CTL_RESET     = 8'h00;
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam logic [15:0] CNT_STOP_INIT = 16'hffff;
    localparam logic [15:0] CNT_READ_IDLE = 16'h0000;

    // Prescaler ratios for count clock select codes 0 to 7.
    localparam logic [10:0] DIV_RATIO [8] = '{11'h002, 11'h004, 11'h008, 11'h010,
                                              11'h020, 11'h040, 11'h100, 11'h400};

    // Timing: system clock, base clock ratio and start delay.
    localparam int SYS_CLK_HZ       = 10_000_000;
    localparam int BASE_DIV         = 2;
    localparam int START_DELAY_BASE = 2;
    localparam int START_DELAY_CYC  = START_DELAY_BASE * BASE_DIV;

    // Operating modes.
    typedef enum logic [3:0] {
        MD_INTERVAL  = 4'h0,
        MD_EVENT     = 4'h1,
        MD_EXT_TRIG  = 4'h2,
        MD_ONE_SHOT  = 4'h3,
        MD_PWM       = 4'h4,
        MD_FREE_RUN  = 4'h5,
        MD_PW_MEAS   = 4'h6,
        MD_TRI_PWM   = 4'h7,
        MD_ENC_CMP   = 4'h8,
        MD_ENC_CAP   = 4'h9,
        MD_ENC_CAPCMP = 4'ha,
        MD_OFFSET_TRIG = 4'hc
    } tcm_mode_e;

    // Run sequencer, Gray coded along stop, delay, run.
    typedef enum logic [1:0] {
        RUN_STOPPED = 2'b00,
        RUN_DELAY   = 2'b01,
        RUN_ACTIVE  = 2'b11
    } tcm_run_e;

    // State of one timer unit.
    typedef struct packed {
        logic [7:0]  ctl0;
        logic [7:0]  ctl1;
        logic [7:0]  ctl2;
        logic        est_pend;
        logic [15:0] tcw;
        logic [15:0] cnt;
        logic        dir_down;
        tcm_run_e    run;
        logic [2:0]  dly;
        logic [9:0]  pre;
        logic        ev_q;
        logic        tick;
        logic        trig;
        logic        cap_clr;
    } tcm_unit_s;

    // Whole block state.
    typedef struct packed {
        tcm_unit_s [NUM_UNITS-1:0] unit;
        logic                      aph_valid;
        logic                      aph_write;
        logic [31:0]               aph_addr;
        logic [31:0]               hrdata;
    } tcm_state_s;

    // Byte address of a register index.
    function automatic logic [31:0] byte_addr(logic [31:0] idx);
        return {idx[29:0], 2'b00};
    endfunction : byte_addr

endpackage : tcm_pkg

// [design/tcm_timer_ctrl.sv]
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Stopped timer: clock low, logic reset
// - Prescale codes select divide 2 to 1024
// - First count follows short base-clock delay
// - One-shot: soft trigger write triggers
// - Pulse mode: trigger on write or start
// - Soft trigger bit always reads zero
// - External clock select, ignored in some modes
// - Mode field picks one of twelve modes
// - Control register 2 only in encoder modes
// - Stop without hold initialises counter, captures
// - Start without hold loads write buffer
// - Stop with hold keeps counter and flags
// - Stop with hold resets compare, outputs
// - Non-encoder stop resets internal state
// - Reload from register 0 on underflow
// - Match-1 clear on downward count
// - Control registers byte access, reset zero
// - Read buffer zero or held after stop
module tcm_timer_ctrl (
    // Clock and reset.
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // AHB-Lite slave port.
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // Inputs from the counting datapath and pins.
    input  wire logic [1:0]                   external_event_pin,
    input  wire logic [1:0][1:0]              event_edge_select,
    input  wire logic [1:0]                   count_up_req,
    input  wire logic [1:0]                   count_down_req,
    input  wire logic [1:0][15:0]             capture_compare_zero,
    input  wire logic [1:0][15:0]             capture_compare_one,
    // Control outputs to the counting datapath.
    output logic [1:0]                        op_clock_en,
    output logic [1:0]                        timer_rst_n,
    output logic [1:0]                        partial_rst_n,
    output logic [1:0]                        count_tick,
    output logic [1:0]                        soft_trigger,
    output logic [1:0][3:0]                   operating_mode_field,
    output logic [1:0]                        mode_illegal,
    output logic [1:0]                        encoder_active,
    output logic [1:0][1:0]                   encoder_count_mode,
    output logic [1:0]                        match0_clear_en,
    output logic [1:0]                        capture_clear,
    output logic [1:0]                        counter_running,
    output logic [1:0][15:0]                  counter_value
);

    // Registered state and its next value.
    tcm_pkg::tcm_state_s state_reg;
    tcm_pkg::tcm_state_s state_next;

    // Decode of the mode field into encoder groupings.
    function automatic logic is_enc(logic [3:0] md);
        return md == tcm_pkg::MD_ENC_CMP || md == tcm_pkg::MD_ENC_CAP || md == tcm_pkg::MD_ENC_CAPCMP;
    endfunction : is_enc

    // Codes outside the table are prohibited; they are flagged, not refused.
    function automatic logic is_legal(logic [3:0] md);
        return md <= tcm_pkg::MD_ENC_CAPCMP || md == tcm_pkg::MD_OFFSET_TRIG;
    endfunction : is_legal

    // Next-state logic: bus writes first, then run control, then bus reads.
    // Reads sample the post-write state so a read right after a write is coherent.
    always_comb
    begin
        logic [3:0]  md;
        logic        enc;
        logic        hold;
        logic        ce_now;
        logic        ce_was;
        logic        ext_edge;
        logic        pre_hit;
        logic        use_ext;
        logic        reload_ok;
        logic [9:0]  lim;
        logic [31:0] rd;
        md        = 4'h0;
        enc       = 1'b0;
        hold      = 1'b0;
        ce_now    = 1'b0;
        ce_was    = 1'b0;
        ext_edge  = 1'b0;
        pre_hit   = 1'b0;
        use_ext   = 1'b0;
        reload_ok = 1'b0;
        lim       = 10'h000;
        rd        = 32'h0000_0000;
        state_next = state_reg;

        for (int u = 0; u < tcm_pkg::NUM_UNITS; u++)
        begin
            // Single-cycle strobes drop back each cycle.
            state_next.unit[u].tick    = 1'b0;
            state_next.unit[u].trig    = 1'b0;
            state_next.unit[u].cap_clr = 1'b0;

            // Data phase of a write; whole-byte writes of the low lane, the low halfword for the write buffer.
            if (state_reg.aph_valid && state_reg.aph_write)
            begin
                if (state_reg.aph_addr == tcm_pkg::byte_addr(tcm_pkg::IDX_CTL0[u]))
                begin
                    state_next.unit[u].ctl0 = hwdata[7:0] & tcm_pkg::CTL0_MASK;
                end
                if (state_reg.aph_addr == tcm_pkg::byte_addr(tcm_pkg::IDX_CTL1[u]))
                begin
                    // The trigger bit is never stored, so it reads as zero.
                    state_next.unit[u].ctl1 = hwdata[7:0] & tcm_pkg::CTL1_MASK;
                    if (hwdata[tcm_pkg::CTL1_EST])
                    begin
                        md = state_next.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4];
                        if (state_reg.unit[u].ctl0[tcm_pkg::CTL0_CE])
                        begin
                            // Running: a trigger write fires at once in one-shot and external trigger modes.
                            if (md == tcm_pkg::MD_ONE_SHOT || md == tcm_pkg::MD_EXT_TRIG)
                            begin
                                state_next.unit[u].trig = 1'b1;
                            end
                        end
                        else
                        begin
                            // Stopped: remember it for the start edge.
                            state_next.unit[u].est_pend = 1'b1;
                        end
                    end
                    else if (!state_reg.unit[u].ctl0[tcm_pkg::CTL0_CE])
                    begin
                        state_next.unit[u].est_pend = 1'b0;
                    end
                end
                if (state_reg.aph_addr == tcm_pkg::byte_addr(tcm_pkg::IDX_CTL2[u]))
                begin
                    state_next.unit[u].ctl2 = hwdata[7:0] & tcm_pkg::CTL2_MASK;
                end
                if (state_reg.aph_addr == tcm_pkg::byte_addr(tcm_pkg::IDX_TCW[u]))
                begin
                    state_next.unit[u].tcw = hwdata[15:0];
                end
            end

            // Working copies of the controls as they stand after the write.
            md     = state_next.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4];
            enc    = is_enc(md);
            // Register 2 settings only count in the encoder modes.
            hold   = enc && state_next.unit[u].ctl2[tcm_pkg::CTL2_ECC];
            ce_now = state_next.unit[u].ctl0[tcm_pkg::CTL0_CE];
            ce_was = state_reg.unit[u].ctl0[tcm_pkg::CTL0_CE];

            // Prescaler terminal count for the selected ratio.
            lim = 10'(tcm_pkg::DIV_RATIO[state_reg.unit[u].ctl0[tcm_pkg::CTL0_CKS +: 3]] - 11'h001);
            pre_hit = state_reg.unit[u].pre == lim;

            // Edge detector on the external event pin, per selected edge.
            unique case (event_edge_select[u])
                2'b01:   ext_edge = external_event_pin[u] && !state_reg.unit[u].ev_q;
                2'b10:   ext_edge = !external_event_pin[u] && state_reg.unit[u].ev_q;
                2'b11:   ext_edge = external_event_pin[u] != state_reg.unit[u].ev_q;
                default: ext_edge = 1'b0;
            endcase

            // The external clock bit is ignored in event and encoder modes.
            use_ext = state_reg.unit[u].ctl1[tcm_pkg::CTL1_EEE] && md != tcm_pkg::MD_EVENT && !enc;

            // Run sequencer: stopped, start delay, counting.
            unique case (state_reg.unit[u].run)
                tcm_pkg::RUN_STOPPED:
                begin
                    // Divider and delay held clear so every start has the same latency.
                    state_next.unit[u].pre = 10'h000;
                    state_next.unit[u].dly = 3'h0;
                    // Pin edge detector is kept at rest while stopped.
                    state_next.unit[u].ev_q = 1'b0;
                end
                tcm_pkg::RUN_DELAY:
                begin
                    // Fixed start delay in base clocks, then the first count period.
                    state_next.unit[u].dly = state_reg.unit[u].dly + 3'h1;
                    // Track the pin so that a level already high is not taken as an edge.
                    state_next.unit[u].ev_q = external_event_pin[u];
                    if (state_reg.unit[u].dly == 3'(tcm_pkg::START_DELAY_CYC - 1))
                    begin
                        state_next.unit[u].run = tcm_pkg::RUN_ACTIVE;
                    end
                end
                tcm_pkg::RUN_ACTIVE:
                begin
                    state_next.unit[u].ev_q = external_event_pin[u];
                    state_next.unit[u].pre  = pre_hit ? 10'h000 : state_reg.unit[u].pre + 10'h001;
                    if (use_ext || md == tcm_pkg::MD_EVENT)
                    begin
                        state_next.unit[u].tick = ext_edge;
                    end
                    else
                    begin
                        state_next.unit[u].tick = pre_hit;
                    end
                end
                default:
                begin
                    state_next.unit[u].run = tcm_pkg::RUN_STOPPED;
                end
            endcase

            // Encoder counter: counts requests decoded by the datapath.
            if (state_reg.unit[u].run == tcm_pkg::RUN_ACTIVE && enc &&
                (count_up_req[u] != count_down_req[u]))
            begin
                state_next.unit[u].dir_down = count_down_req[u];
                reload_ok = state_next.unit[u].ctl2[tcm_pkg::CTL2_LDE] &&
                            !state_next.unit[u].ctl2[tcm_pkg::CTL2_ECM1] &&
                            (md == tcm_pkg::MD_ENC_CMP || md == tcm_pkg::MD_ENC_CAP);
                if (count_up_req[u])
                begin
                    state_next.unit[u].cnt = state_reg.unit[u].cnt + 16'h0001;
                end
                else if (md == tcm_pkg::MD_ENC_CMP && state_next.unit[u].ctl2[tcm_pkg::CTL2_ECM1] &&
                         state_reg.unit[u].cnt == capture_compare_one[u])
                begin
                    // Match with register 1 on a downward step clears instead.
                    state_next.unit[u].cnt = 16'h0000;
                end
                else if (state_reg.unit[u].cnt == 16'h0000 && reload_ok)
                begin
                    // Underflow reloads from register 0 when enabled.
                    state_next.unit[u].cnt = capture_compare_zero[u];
                end
                else
                begin
                    state_next.unit[u].cnt = state_reg.unit[u].cnt - 16'h0001;
                end
            end

            // Start edge of the run bit.
            if (ce_now && !ce_was)
            begin
                state_next.unit[u].run = tcm_pkg::RUN_DELAY;
                state_next.unit[u].pre = 10'h000;
                state_next.unit[u].dly = 3'h0;
                if (enc && !hold)
                begin
                    // Without hold the counter starts from the write buffer.
                    state_next.unit[u].cnt = state_next.unit[u].tcw;
                end
                if (state_reg.unit[u].est_pend && md == tcm_pkg::MD_EXT_TRIG)
                begin
                    // A trigger armed while stopped fires on start in external trigger mode.
                    state_next.unit[u].trig = 1'b1;
                end
                state_next.unit[u].est_pend = 1'b0;
            end

            // Stop edge of the run bit.
            if (!ce_now && ce_was)
            begin
                state_next.unit[u].run  = tcm_pkg::RUN_STOPPED;
                // A count pulse from the last running cycle must not leave a stopped unit.
                state_next.unit[u].tick = 1'b0;
                state_next.unit[u].ev_q = 1'b0;
                state_next.unit[u].pre  = 10'h000;
                if (enc && !hold)
                begin
                    // Counter to all ones, captures and flags cleared.
                    state_next.unit[u].cnt      = tcm_pkg::CNT_STOP_INIT;
                    state_next.unit[u].dir_down = 1'b0;
                    state_next.unit[u].cap_clr  = 1'b1;
                end
                // With hold the counter and direction are left as they are.
            end
        end

        // Address phase: capture a valid transfer while the bus is ready.
        if (hready)
        begin
            state_next.aph_valid = hsel && htrans[1];
            state_next.aph_write = hwrite;
            state_next.aph_addr  = haddr;
            // Read data is prepared now so it stands in the data phase.
            if (hsel && htrans[1] && !hwrite)
            begin
                for (int u = 0; u < tcm_pkg::NUM_UNITS; u++)
                begin
                    md = state_next.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4];
                    if (haddr == tcm_pkg::byte_addr(tcm_pkg::IDX_CTL0[u]))
                    begin
                        rd = {24'h00_0000, state_next.unit[u].ctl0};
                    end
                    if (haddr == tcm_pkg::byte_addr(tcm_pkg::IDX_CTL1[u]))
                    begin
                        rd = {24'h00_0000, state_next.unit[u].ctl1};
                    end
                    if (haddr == tcm_pkg::byte_addr(tcm_pkg::IDX_CTL2[u]))
                    begin
                        rd = {24'h00_0000, state_next.unit[u].ctl2};
                    end
                    if (haddr == tcm_pkg::byte_addr(tcm_pkg::IDX_TCW[u]))
                    begin
                        rd = {16'h0000, state_next.unit[u].tcw};
                    end
                    if (haddr == tcm_pkg::byte_addr(tcm_pkg::IDX_CNT[u]))
                    begin
                        // Stopped without hold reads zero; with hold the kept value.
                        if (!state_next.unit[u].ctl0[tcm_pkg::CTL0_CE] &&
                            !(is_enc(md) && state_next.unit[u].ctl2[tcm_pkg::CTL2_ECC]))
                        begin
                            rd = {16'h0000, tcm_pkg::CNT_READ_IDLE};
                        end
                        else
                        begin
                            rd = {16'h0000, state_next.unit[u].cnt};
                        end
                    end
                end
            end
            // Unmapped reads return zero.
            state_next.hrdata = rd;
        end
    end

    // State register; every field clears on reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Bus answers: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = state_reg.hrdata;

    // Per-unit outputs to the counting datapath.
    always_comb
    begin
        for (int u = 0; u < tcm_pkg::NUM_UNITS; u++)
        begin
            // Operating clock stands low whenever the run bit is clear.
            op_clock_en[u] = state_reg.unit[u].ctl0[tcm_pkg::CTL0_CE];
            // Full reset while stopped, except encoder hold keeps the counter side.
            timer_rst_n[u] = state_reg.unit[u].ctl0[tcm_pkg::CTL0_CE] ||
                             (is_enc(state_reg.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4]) &&
                              state_reg.unit[u].ctl2[tcm_pkg::CTL2_ECC]);
            // Compare detector, timer outputs and other edge detectors reset whenever stopped, hold or not.
            partial_rst_n[u] = state_reg.unit[u].ctl0[tcm_pkg::CTL0_CE];
            count_tick[u]    = state_reg.unit[u].tick;
            soft_trigger[u]  = state_reg.unit[u].trig;
            operating_mode_field[u] = state_reg.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4];
            mode_illegal[u]   = !is_legal(state_reg.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4]);
            encoder_active[u] = is_enc(state_reg.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4]);
            // Register 2 fields reach the datapath only in encoder modes.
            encoder_count_mode[u] = encoder_active[u] ? state_reg.unit[u].ctl2[tcm_pkg::CTL2_UDS +: 2] : 2'b00;
            match0_clear_en[u] = encoder_active[u] && state_reg.unit[u].ctl1[tcm_pkg::CTL1_MD +: 4] == tcm_pkg::MD_ENC_CMP
                                 && state_reg.unit[u].ctl2[tcm_pkg::CTL2_ECM0];
            capture_clear[u]   = state_reg.unit[u].cap_clr;
            counter_running[u] = state_reg.unit[u].run == tcm_pkg::RUN_ACTIVE;
            counter_value[u]   = state_reg.unit[u].cnt;
        end
    end

endmodule : tcm_timer_ctrl

// [sim/tcm_timer_ctrl_properties.sv]
`timescale 1ns/1ps
// Watches unit 0; unit 1 shares the same logic, so one unit keeps the checker small.
module tcm_chk (
    // Clock and reset.
    input wire logic            hclk,
    input wire logic            hresetn,
    // Observed outputs.
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire logic [1:0]      op_clock_en,
    input wire logic [1:0]      timer_rst_n,
    input wire logic [1:0]      count_tick,
    input wire logic [1:0][3:0] operating_mode_field,
    input wire logic [1:0]      mode_illegal,
    input wire logic [1:0]      encoder_active,
    input wire logic [1:0][1:0] encoder_count_mode,
    input wire logic [1:0]      match0_clear_en,
    input wire logic [1:0]      counter_running
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
    chk_stop_quiet: assert property (!op_clock_en[0] |-> !count_tick[0] && !counter_running[0])
        else $error("stopped unit counts");
    chk_start_delay: assert property ($rose(op_clock_en[0]) |-> !count_tick[0] [*4]) else $error("early count");
    chk_tick_pulse: assert property (count_tick[0] |=> !count_tick[0]) else $error("count tick too long");
    chk_enc_decode: assert property (encoder_active[0] == (operating_mode_field[0] inside {4'h8, 4'h9, 4'ha}))
        else $error("encoder decode wrong");
    chk_illegal_mode: assert property (mode_illegal[0] == (operating_mode_field[0] == 4'hb
        || operating_mode_field[0] > 4'hc)) else $error("illegal mode decode wrong");
    chk_enc_only: assert property (!encoder_active[0] |-> encoder_count_mode[0] == 2'b00 && !match0_clear_en[0])
        else $error("encoder option outside encoder mode");
    chk_stop_reset: assert property (!op_clock_en[0] && !$past(op_clock_en[0]) && timer_rst_n[0]
        |-> encoder_active[0]) else $error("stopped unit not reset");
endmodule : tcm_chk
bind tcm_timer_ctrl tcm_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .op_clock_en(op_clock_en), .timer_rst_n(timer_rst_n), .count_tick(count_tick),
    .operating_mode_field(operating_mode_field), .mode_illegal(mode_illegal), .encoder_active(encoder_active),
    .encoder_count_mode(encoder_count_mode), .match0_clear_en(match0_clear_en), .counter_running(counter_running));

// [sim/tcm_timer_ctrl_tb.sv]
`timescale 1ns/1ps
module tcm_timer_ctrl_tb;
    logic             hclk, hresetn, hsel, hwrite, hreadyout, ev;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [1:0]       htrans, up_req, op_clock_en, timer_rst_n, count_tick, soft_trigger, prst;
    logic [2:0]       hsize;
    logic [1:0][3:0]  md;
    logic [1:0][15:0] cval;
    int               fails, n_tests, ticks, trigs, t, k;
    localparam logic [31:0] C0 = tcm_pkg::IDX_CTL0[0], C1 = tcm_pkg::IDX_CTL1[0], C2 = tcm_pkg::IDX_CTL2[0];
    tcm_timer_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
        .hrdata(hrdata), .external_event_pin({1'b0, ev}), .event_edge_select(4'h1), .count_up_req(up_req),
        .count_down_req(2'b00), .capture_compare_zero(32'h0), .capture_compare_one(32'h0),
        .op_clock_en(op_clock_en), .timer_rst_n(timer_rst_n), .partial_rst_n(prst), .count_tick(count_tick),
        .soft_trigger(soft_trigger), .operating_mode_field(md), .mode_illegal(), .encoder_active(),
        .encoder_count_mode(), .match0_clear_en(), .capture_clear(), .counter_running(), .counter_value(cval));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Count pulses so one-cycle outputs are never missed between bus transfers.
    always @(posedge hclk) begin
        ticks <= ticks + count_tick[0];
        trigs <= trigs + soft_trigger[0];
    end
    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // Port levels are read on a later falling edge, once the last write has settled.
    task automatic settle;
        repeat (2) @(negedge hclk);
    endtask : settle
    task automatic edge_rdy;
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin fails++; tally_and_finish; end
    endtask : edge_rdy
    // One single AHB transfer; the byte address is four times the register index.
    task automatic xfer(input logic w, input logic [31:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {idx[29:0], 2'b00};
        edge_rdy;
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        edge_rdy;
        rd = hrdata;
    endtask : xfer
    task automatic wait_tick;
        t = ticks;
        k = 0;
        while (ticks == t && k < 1100) begin @(posedge hclk); k++; end
        if (k >= 1100) begin fails++; tally_and_finish; end
    endtask : wait_tick
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
        hwdata = 32'h0; up_req = 2'b00; fails = 0; n_tests = 0; ticks = 0; trigs = 0; ev = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int u = 0; u < 2; u++)
        begin
            xfer(0, tcm_pkg::IDX_CTL0[u], 0); cmp(rd, 32'h0);
            xfer(0, tcm_pkg::IDX_CTL1[u], 0); cmp(rd, 32'h0);
            xfer(0, tcm_pkg::IDX_CTL2[u], 0); cmp(rd, 32'h0);
        end
        xfer(0, 32'h3fff0000, 0); cmp(rd, 32'h0);
        for (int m = 0; m < 16; m++) begin xfer(1, C1, m); settle; cmp(md[0], m); end
        xfer(1, C1, 32'h6f); xfer(0, C1, 0); cmp(rd, 32'h2f);
        xfer(1, C1, 32'h00);
        // Each divide code: spacing of counts; the first count delay is checked for code 0 only.
        for (int c = 0; c < 8; c++)
        begin
            xfer(1, C0, 32'h80 | c);
            wait_tick;
            if (c == 0) cmp(k >= 4 && k <= 12, 1);
            wait_tick;
            cmp(k, c < 6 ? 2 << c : (c == 6 ? 256 : 1024));
            xfer(1, C0, c); settle; cmp(timer_rst_n[0], 0);
        end
        // External clock: only pin edges count, the slow prescaler never ticks here.
        xfer(1, C1, 32'h20); xfer(1, C0, 32'h87); repeat (8) @(posedge hclk); t = ticks;
        repeat (3) begin ev <= 1'b1; @(posedge hclk); ev <= 1'b0; @(posedge hclk); end
        settle; cmp(ticks - t, 3);
        xfer(1, C0, 32'h07);
        xfer(1, C1, 32'h03); xfer(1, C0, 32'h80); t = trigs;
        xfer(1, C1, 32'h43); settle; cmp(trigs - t, 1);
        xfer(1, C0, 32'h00); xfer(1, C1, 32'h42); t = trigs;
        xfer(1, C0, 32'h80); settle; cmp(trigs - t, 1);
        xfer(1, C0, 32'h00); xfer(1, C1, 32'h08); xfer(1, C2, 32'h00);
        xfer(1, tcm_pkg::IDX_TCW[0], 32'h1234); xfer(1, C0, 32'h80); settle; cmp(cval[0], 32'h1234);
        xfer(1, C0, 32'h00); settle; cmp(cval[0], 32'hffff);
        xfer(0, tcm_pkg::IDX_CNT[0], 0); cmp(rd, 32'h0);
        // With hold the start keeps ffff; two up counts leave 0001 to survive the stop.
        xfer(1, C2, 32'h80); xfer(1, C0, 32'h80); repeat (8) @(posedge hclk);
        repeat (2) begin up_req <= 2'b01; @(posedge hclk); up_req <= 2'b00; @(posedge hclk); end
        settle; cmp(cval[0], 32'h0001);
        xfer(1, C0, 32'h00); settle; cmp(timer_rst_n[0], 1);
        cmp(prst[0], 0);
        settle; cmp(cval[0], 32'h0001);
        xfer(0, tcm_pkg::IDX_CNT[0], 0); cmp(rd, 32'h0001);
        tally_and_finish;
    end
endmodule : tcm_timer_ctrl_tb
